// *** verilog/mtp_consts.svh ***
// Register offsets, field positions, reset values and counts of the timer block.
`ifndef MTP_CONSTS_SVH
`define MTP_CONSTS_SVH
`define MTP_OFF_START 8'h00
`define MTP_OFF_A_MODE 8'h04
`define MTP_OFF_A_TIMER 8'h08
`define MTP_OFF_INT_STAT 8'h0C
`define MTP_OFF_INT_MASK 8'h10
`define MTP_OFF_B_TIMER 8'h20
`define MTP_OFF_B_MODE 8'h40
`define MTP_B_SPAN 8'h18
`define MTP_AM_CLK_LSB 0
`define MTP_AM_8BIT 2
`define MTP_AM_TRIG_EN 3
`define MTP_AM_TRIG_SRC 4
`define MTP_BM_MODE_LSB 0
`define MTP_BM_EDGE_LSB 2
`define MTP_BM_CLK_LSB 4
`define MTP_BM_SRC 6
`define MTP_RST_TIMER 16'h0000
`define MTP_RST_A_MODE 5'h00
`define MTP_RST_B_MODE 7'h00
`define MTP_RST_FLAGS 7'h00
`define MTP_CYC16_LAST 16'hFFFE
`define MTP_CYC8_LAST 16'h00FE
`define MTP_DIV8_LAST 3'h7
`define MTP_DIV32_LAST 5'h1F
`define MTP_A_UNDEF 16'hFFFF
`endif

// *** verilog/mtp_pkg.sv ***
// Types and the count-source selector shared by the timer block.
package mtp_pkg;
  typedef struct packed {
    logic one;
    logic eight;
    logic t32;
    logic sub32;
  } mtp_tick_s;
  typedef enum logic [1:0] {
    MTP_A_IDLE = 2'h0,
    MTP_A_ARMED = 2'h1,
    MTP_A_RUN = 2'h3
  } mtp_a_state_e;
  typedef enum logic [1:0] {
    MTP_B_TIMER = 2'h0,
    MTP_B_EVENT = 2'h1,
    MTP_B_MEAS = 2'h2,
    MTP_B_RSVD = 2'h3
  } mtp_b_mode_e;
  // Picks one count-source enable by a two-bit select.
  function automatic logic sel_tick(input mtp_tick_s t, input logic [1:0] sel);
    case (sel)
      2'h0: sel_tick = t.one;
      2'h1: sel_tick = t.eight;
      2'h2: sel_tick = t.t32;
      default: sel_tick = t.sub32;
    endcase
  endfunction
endpackage

// *** verilog/mtp_prescale.sv ***
// Count-source divider: one-cycle enables at clock/1, /8, /32 and sub-clock/32.
`timescale 1ns/1ps
`default_nettype none
`include "mtp_consts.svh"
module mtp_prescale (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic subclk_tick_i,
  output var mtp_pkg::mtp_tick_s ticks_o
);
  typedef struct packed {
    logic [2:0] c8;
    logic [4:0] c32;
    logic [4:0] cs;
    mtp_pkg::mtp_tick_s t;
  } mtp_pre_s;
  mtp_pre_s s_r, s_nxt;
  // Free-running dividers; the sub-clock divides only on its own enable pulses.
  always_comb begin
    s_nxt = s_r;
    s_nxt.c8 = s_r.c8 + 3'h1;
    s_nxt.c32 = s_r.c32 + 5'h01;
    s_nxt.t.one = 1'b1;
    s_nxt.t.eight = (s_r.c8 == `MTP_DIV8_LAST);
    s_nxt.t.t32 = (s_r.c32 == `MTP_DIV32_LAST);
    s_nxt.t.sub32 = subclk_tick_i && (s_r.cs == `MTP_DIV32_LAST);
    if (subclk_tick_i) begin
      s_nxt.cs = s_r.cs + 5'h01;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign ticks_o = s_r.t;
endmodule
`default_nettype wire

// *** verilog/mtp_b_chan.sv ***
// One type-B channel: down counter with reload in timer and event counter modes.
`timescale 1ns/1ps
`default_nettype none
`include "mtp_consts.svh"
module mtp_b_chan #(
  parameter int W = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire mtp_pkg::mtp_tick_s tick_i,
  input wire logic [6:0] mode_i,
  input wire logic start_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic pin_i,
  input wire logic nbr_uf_i,
  output logic [W-1:0] count_o,
  output logic uf_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] reload;
    logic pin_prev;
    logic uf;
  } mtp_b_s;
  mtp_b_s s_r, s_nxt;
  logic [1:0] mode;
  logic [1:0] edge_sel;
  logic run;
  logic edge_hit;
  logic tick;
  // Count-source choice, edge detect, count and reload.
  always_comb begin
    s_nxt = s_r;
    s_nxt.uf = 1'b0;
    s_nxt.pin_prev = pin_i;
    mode = mode_i[`MTP_BM_MODE_LSB +: 2];
    edge_sel = mode_i[`MTP_BM_EDGE_LSB +: 2];
    run = start_i && (mode == mtp_pkg::MTP_B_TIMER || mode == mtp_pkg::MTP_B_EVENT);
    case (edge_sel)
      2'h0: edge_hit = !pin_i && s_r.pin_prev;
      2'h1: edge_hit = pin_i && !s_r.pin_prev;
      default: edge_hit = pin_i != s_r.pin_prev;
    endcase
    if (mode == mtp_pkg::MTP_B_TIMER) begin
      tick = mtp_pkg::sel_tick(tick_i, mode_i[`MTP_BM_CLK_LSB +: 2]);
    end else begin
      tick = mode_i[`MTP_BM_SRC] ? nbr_uf_i : edge_hit;
    end
    if (run && tick) begin
      if (s_r.cnt == '0) begin
        s_nxt.cnt = s_r.reload;
        s_nxt.uf = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - W'(1);
      end
    end
    // A write while counting only reaches the reload value.
    if (wr_i) begin
      s_nxt.reload = wdata_i;
      if (!run) begin
        s_nxt.cnt = wdata_i;
      end
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign count_o = s_r.cnt;
  assign uf_o = s_r.uf;
endmodule
`default_nettype wire

// *** verilog/mtp_top.sv ***
// Timer block top: type-A PWM channel, six type-B channels, registers and interrupt.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mtp_consts.svh"
// Functional notes
// - The A counter counts down as a 16-bit or an 8-bit prescaled modulator.
// - The counter reloads at each rising output edge and flags an interrupt when it falls.
// - Triggers that arrive while the modulator is counting are ignored.
// - In 16-bit mode the output is high n periods in a fixed cycle of 65535 periods.
// - In 8-bit mode low byte m prescales by m+1, high n*(m+1) in a 255*(m+1) cycle.
// - Counting starts on a pin trigger, a B0 overflow, or the start flag alone.
// - Clearing the start flag stops the modulator.
// - The trigger pin is a trigger or plain input; the pulse pin carries the PWM wave.
// - Reading the A timer register returns an undefined value, not the count.
// - A timer write when stopped loads reload and counter, when running only reload.
// - Each B channel 0 to 5 picks timer or event mode from two low bits; measurement mode holds it stopped.
// - B timer mode counts a divided clock down, reloads on underflow and interrupts.
// - A B channel divides its count source by the set value plus one.
// - A B channel runs while its start flag is one and halts when cleared.
// - Reading a B timer register returns its live count.
// - B event mode counts pin edges, rising, falling or both, or another overflow.
module mtp_top #(
  parameter int BW = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic a_channel_trigger_pin_i,
  output logic a_channel_pulse_pin_o,
  input wire logic [5:0] b_channel_count_pin_i,
  input wire logic subclk_tick_i,
  output logic irq_o
);
  typedef struct packed {
    mtp_pkg::mtp_a_state_e st;
    logic [15:0] reload;
    logic [15:0] high;
    logic [15:0] cyc;
    logic [7:0] pre;
    logic [7:0] pm;
    logic out;
    logic trig_prev;
    logic [6:0] start;
    logic [4:0] a_mode;
    logic [5:0][6:0] b_mode;
    logic [6:0] status;
    logic [6:0] mask;
    logic irq;
    logic [31:0] rdata;
  } mtp_top_s;

  mtp_top_s s_r, s_nxt;
  mtp_pkg::mtp_tick_s ticks;
  logic [5:0][BW-1:0] b_count;
  logic [5:0] b_uf;
  logic [5:0] b_wr;
  logic tick_a;
  logic trig;
  logic mode8;
  logic restart;
  logic a_evt;
  logic [6:0] clr;
  logic [3:0] hit_t;
  logic [3:0] hit_m;

  // Decodes a B register window: bit 3 is the hit, bits 2:0 the channel.
  function automatic logic [3:0] b_decode(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    b_decode = 4'h0;
    if (a >= base && d < `MTP_B_SPAN && d[1:0] == 2'h0) begin
      b_decode = {1'b1, d[4:2]};
    end
  endfunction

  mtp_prescale u_pre (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .subclk_tick_i(subclk_tick_i),
    .ticks_o(ticks)
  );

  assign hit_t = b_decode(addr_i, `MTP_OFF_B_TIMER);
  assign hit_m = b_decode(addr_i, `MTP_OFF_B_MODE);

  // Six B channels; each takes its lower neighbour's underflow as event source, and B0 takes B5's.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_b
      assign b_wr[gi] = wr_i && hit_t[3] && (hit_t[2:0] == 3'(gi));
      mtp_b_chan #(
        .W(BW)
      ) u_b (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_i(ticks),
        .mode_i(s_r.b_mode[gi]),
        .start_i(s_r.start[gi+1]),
        .wr_i(b_wr[gi]),
        .wdata_i(wdata_i[BW-1:0]),
        .pin_i(b_channel_count_pin_i[gi]),
        .nbr_uf_i(b_uf[(gi+5)%6]),
        .count_o(b_count[gi]),
        .uf_o(b_uf[gi])
      );
    end
  endgenerate

  // Modulator sequence, register writes, interrupt status and read data.
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0000_0000;
    restart = 1'b0;
    a_evt = 1'b0;
    clr = 7'h00;
    mode8 = s_r.a_mode[`MTP_AM_8BIT];
    tick_a = mtp_pkg::sel_tick(ticks, s_r.a_mode[`MTP_AM_CLK_LSB +: 2]);
    trig = s_r.a_mode[`MTP_AM_TRIG_SRC] ? b_uf[0] : (a_channel_trigger_pin_i && !s_r.trig_prev);
    s_nxt.trig_prev = a_channel_trigger_pin_i;
    if (!s_r.start[0]) begin
      s_nxt.st = mtp_pkg::MTP_A_IDLE;
      s_nxt.out = 1'b0;
    end else begin
      case (s_r.st)
        mtp_pkg::MTP_A_IDLE: begin
          if (s_r.a_mode[`MTP_AM_TRIG_EN]) begin
            s_nxt.st = mtp_pkg::MTP_A_ARMED;
          end else begin
            s_nxt.st = mtp_pkg::MTP_A_RUN;
            restart = 1'b1;
          end
        end
        mtp_pkg::MTP_A_ARMED: begin
          if (trig) begin
            s_nxt.st = mtp_pkg::MTP_A_RUN;
            restart = 1'b1;
          end
        end
        mtp_pkg::MTP_A_RUN: begin
          if (tick_a) begin
            if (s_r.pre != 8'h00) begin
              s_nxt.pre = s_r.pre - 8'h01;
            end else begin
              s_nxt.pre = s_r.pm;
              if (s_r.cyc == 16'h0000) begin
                restart = 1'b1;
              end else begin
                s_nxt.cyc = s_r.cyc - 16'h0001;
                if (s_r.high != 16'h0000) begin
                  s_nxt.high = s_r.high - 16'h0001;
                  if (s_r.high == 16'h0001) begin
                    s_nxt.out = 1'b0;
                    a_evt = 1'b1;
                  end
                end
              end
            end
          end
        end
        default: s_nxt.st = mtp_pkg::MTP_A_IDLE;
      endcase
    end
    // Restart loads high n and the fixed cycle, with prescale m in 8-bit mode.
    if (restart) begin
      s_nxt.cyc = mode8 ? `MTP_CYC8_LAST : `MTP_CYC16_LAST;
      s_nxt.high = mode8 ? {8'h00, s_r.reload[15:8]} : s_r.reload;
      s_nxt.pm = mode8 ? s_r.reload[7:0] : 8'h00;
      s_nxt.pre = mode8 ? s_r.reload[7:0] : 8'h00;
      s_nxt.out = mode8 ? (s_r.reload[15:8] != 8'h00) : (s_r.reload != 16'h0000);
    end
    // Register writes; B timer writes go straight to the channels.
    if (wr_i) begin
      case (addr_i)
        `MTP_OFF_START: s_nxt.start = wdata_i[6:0];
        `MTP_OFF_A_MODE: s_nxt.a_mode = wdata_i[4:0];
        `MTP_OFF_A_TIMER: begin
          s_nxt.reload = wdata_i[15:0];
          if (s_r.st != mtp_pkg::MTP_A_RUN) begin
            s_nxt.high = wdata_i[15:0];
          end
        end
        `MTP_OFF_INT_STAT: clr = wdata_i[6:0];
        `MTP_OFF_INT_MASK: s_nxt.mask = wdata_i[6:0];
        default: begin
          if (hit_m[3]) begin
            s_nxt.b_mode[hit_m[2:0]] = wdata_i[6:0];
          end
        end
      endcase
    end
    // Set wins over a write-one clear landing in the same cycle.
    s_nxt.status = (s_r.status & ~clr) | {b_uf, a_evt};
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    // Read data stands only in the cycle after the strobe; unmapped reads give zero.
    if (rd_i) begin
      case (addr_i)
        `MTP_OFF_START: s_nxt.rdata = {25'h0, s_r.start};
        `MTP_OFF_A_MODE: s_nxt.rdata = {27'h0, s_r.a_mode};
        `MTP_OFF_A_TIMER: s_nxt.rdata = {16'h0000, `MTP_A_UNDEF};
        `MTP_OFF_INT_STAT: s_nxt.rdata = {25'h0, s_r.status};
        `MTP_OFF_INT_MASK: s_nxt.rdata = {25'h0, s_r.mask};
        default: begin
          if (hit_t[3]) begin
            s_nxt.rdata = 32'(b_count[hit_t[2:0]]);
          end else if (hit_m[3]) begin
            s_nxt.rdata = {25'h0, s_r.b_mode[hit_m[2:0]]};
          end
        end
      endcase
    end
  end

  // All state in one register; reset leaves every channel stopped.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.st <= mtp_pkg::MTP_A_IDLE;
      s_r.reload <= `MTP_RST_TIMER;
      s_r.a_mode <= `MTP_RST_A_MODE;
      s_r.b_mode <= {6{`MTP_RST_B_MODE}};
      s_r.start <= `MTP_RST_FLAGS;
      s_r.mask <= `MTP_RST_FLAGS;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign a_channel_pulse_pin_o = s_r.out;
  assign irq_o = s_r.irq;

  // Checks of the documented behaviour.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_run_holds;
    (s_r.st == mtp_pkg::MTP_A_RUN && s_r.start[0]) |=> s_r.st == mtp_pkg::MTP_A_RUN;
  endproperty
  a_run_holds: assert property (p_run_holds) else $error("modulator left run state");

  property p_fall_irq;
    ($fell(s_r.out) && $past(s_r.high) == 16'h0001) |-> s_r.status[0];
  endproperty
  a_fall_irq: assert property (p_fall_irq) else $error("no status on falling pulse");

  property p_reload16;
    ($rose(s_r.out) && !$past(mode8)) |-> (s_r.high == $past(s_r.reload)
      && s_r.cyc == `MTP_CYC16_LAST);
  endproperty
  a_reload16: assert property (p_reload16) else $error("16-bit cycle load wrong");

  property p_reload8;
    ($rose(s_r.out) && $past(mode8)) |-> (s_r.pm == $past(s_r.reload[7:0])
      && s_r.high == {8'h00, $past(s_r.reload[15:8])} && s_r.cyc == `MTP_CYC8_LAST);
  endproperty
  a_reload8: assert property (p_reload8) else $error("8-bit cycle load wrong");

  property p_trig_start;
    (s_r.st == mtp_pkg::MTP_A_ARMED && s_r.start[0] && trig) |=> s_r.st == mtp_pkg::MTP_A_RUN;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

  property p_stop;
    !s_r.start[0] |=> (s_r.st == mtp_pkg::MTP_A_IDLE && !s_r.out);
  endproperty
  a_stop: assert property (p_stop) else $error("modulator did not stop");

  property p_a_read;
    (rd_i && addr_i == `MTP_OFF_A_TIMER) |=> rdata_o[15:0] == `MTP_A_UNDEF;
  endproperty
  a_a_read: assert property (p_a_read) else $error("A timer read not undefined");

  property p_a_write;
    (wr_i && addr_i == `MTP_OFF_A_TIMER && s_r.st != mtp_pkg::MTP_A_RUN && s_r.start[0] == 1'b0)
      |=> (s_r.reload == $past(wdata_i[15:0]) && s_r.high == $past(wdata_i[15:0]));
  endproperty
  a_a_write: assert property (p_a_write) else $error("stopped write not loaded");

  property p_b_irq;
    b_uf[0] |=> s_r.status[1];
  endproperty
  a_b_irq: assert property (p_b_irq) else $error("B0 underflow not flagged");

  property p_b_halt;
    (!s_r.start[1] && !b_wr[0]) |=> $stable(b_count[0]);
  endproperty
  a_b_halt: assert property (p_b_halt) else $error("halted B0 counted");

  property p_b_read;
    (rd_i && addr_i == `MTP_OFF_B_TIMER) |=> rdata_o == 32'($past(b_count[0]));
  endproperty
  a_b_read: assert property (p_b_read) else $error("B0 read not live count");

  c_pulse_rise: cover property ($rose(s_r.out));
  c_pulse_fall_irq: cover property ($fell(s_r.out) ##1 irq_o);
  c_b_underflow: cover property (b_uf[0] ##1 s_r.status[1]);
  c_armed_start: cover property (s_r.st == mtp_pkg::MTP_A_ARMED ##1 s_r.st == mtp_pkg::MTP_A_RUN);
endmodule
`default_nettype wire

// *** sim/test_mtp_top.sv ***
// Self-checking bench for the timer block: PWM channel, B channels, registers and interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "mtp_consts.svh"
module test_mtp_top;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic trig = 1'b0;
  logic pulse;
  logic [5:0] bpin = 6'h00;
  logic sub_tick = 1'b0;
  logic irq_o;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 99;
  logic [31:0] start_bits = 32'h0000_0000;
  // Reset-value table: START, INT_STAT, B timer 0, an unmapped hole, A timer.
  logic [7:0] addr_q[$] = '{8'h00, 8'h0C, 8'h20, 8'h3C, 8'h08};
  logic [31:0] exp_q[$] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_FFFF};

  mtp_top #(.BW(16)) i_dut (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .a_channel_trigger_pin_i(trig),
    .a_channel_pulse_pin_o(pulse),
    .b_channel_count_pin_i(bpin),
    .subclk_tick_i(sub_tick),
    .irq_o(irq_o)
  );

  // Clock at 20 MHz.
  always #25 clock_i = ~clock_i;

  // Cycle counter for width and period figures; the sub-clock tick comes every fourth cycle.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    sub_tick <= (cyc % 4 == 0);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Bus tasks start and end one step after a rising edge, so strobes never clash.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Waits for the pulse pin (0) or the interrupt (1) to reach a level, with a bound.
  task automatic wait_for(input int which, input logic v, input int bound, output int t);
    int i;
    for (i = 0; i < bound; i++) begin
      @(posedge clock_i);
      #1;
      if ((which == 0 ? pulse : irq_o) === v) break;
    end
    t = cyc;
    if (i == bound) begin
      err_total++;
      $display("BAD at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask

  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [31:0] d2;
    int t0, t1, t2, n, m, r, k, edges;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    idle(1);
    // Reset values, undefined A read and an unmapped address.
    foreach (addr_q[i]) begin
      reg_rd(addr_q[i], d);
      check(d, exp_q[i]);
    end
    // B channel 2 in timer mode: stopped load, live read, period and interrupt.
    r = 4 + ($random(seed) & 7);
    reg_wr(`MTP_OFF_B_MODE + 8'h08, 32'h0000_0000);
    reg_wr(`MTP_OFF_B_TIMER + 8'h08, 32'(r));
    reg_rd(`MTP_OFF_B_TIMER + 8'h08, d);
    check(d, 32'(r));
    reg_wr(`MTP_OFF_INT_MASK, 32'h0000_0008);
    start_bits = 32'h0000_0008;
    reg_wr(`MTP_OFF_START, start_bits);
    wait_for(1, 1'b1, 40, t1);
    reg_wr(`MTP_OFF_INT_STAT, 32'h0000_0008);
    wait_for(1, 1'b1, 40, t2);
    check(32'(t2 - t1), 32'(r + 1));
    // Masking the source drops the interrupt even though status stays set.
    reg_wr(`MTP_OFF_INT_MASK, 32'h0000_0000);
    idle(2);
    check({31'h0, irq_o}, 32'h0);
    start_bits = 32'h0000_0000;
    reg_wr(`MTP_OFF_START, start_bits);
    reg_rd(`MTP_OFF_B_TIMER + 8'h08, d);
    idle(6);
    reg_rd(`MTP_OFF_B_TIMER + 8'h08, d2);
    check(d2, d);
    reg_wr(`MTP_OFF_INT_STAT, 32'h0000_00FF);
    // B channel 1 in event mode, every edge setting; the model counts qualifying edges.
    for (int e = 0; e < 4; e++) begin
      k = 2 + ($random(seed) & 7);
      reg_wr(`MTP_OFF_B_MODE + 8'h04, 32'(e * 4 + 1));
      reg_wr(`MTP_OFF_B_TIMER + 8'h04, 32'h0000_0014);
      reg_wr(`MTP_OFF_START, 32'h0000_0004);
      idle(3);
      edges = 0;
      repeat (k) begin
        bpin[1] <= ~bpin[1];
        if (bpin[1] == 1'b0 ? e != 0 : e != 1) edges++;
        idle(4);
      end
      reg_wr(`MTP_OFF_START, start_bits);
      reg_rd(`MTP_OFF_B_TIMER + 8'h04, d);
      check(d, 32'(20 - edges));
    end
    // B0 on the /8 source feeds B1 through its underflow, so B1 flags every 32 cycles.
    reg_wr(`MTP_OFF_B_MODE, 32'h0000_0010);
    reg_wr(`MTP_OFF_B_TIMER, 32'h0000_0001);
    reg_wr(`MTP_OFF_B_MODE + 8'h04, 32'h0000_0041);
    reg_wr(`MTP_OFF_B_TIMER + 8'h04, 32'h0000_0001);
    reg_wr(`MTP_OFF_INT_MASK, 32'h0000_0004);
    reg_wr(`MTP_OFF_START, 32'h0000_0006);
    wait_for(1, 1'b1, 80, t1);
    reg_wr(`MTP_OFF_INT_STAT, 32'h0000_0004);
    wait_for(1, 1'b1, 80, t2);
    check(32'(t2 - t1), 32'h0000_0020);
    reg_wr(`MTP_OFF_START, start_bits);
    reg_wr(`MTP_OFF_INT_STAT, 32'h0000_00FF);
    // A channel, 16-bit: high time, interrupt on the fall, fixed cycle, stop while high.
    n = 8 + ($random(seed) & 7);
    reg_wr(`MTP_OFF_INT_MASK, 32'h0000_0001);
    reg_wr(`MTP_OFF_A_TIMER, 32'(n));
    reg_wr(`MTP_OFF_START, 32'h0000_0001);
    wait_for(0, 1'b1, 10, t0);
    wait_for(0, 1'b0, 30, t1);
    check(32'(t1 - t0), 32'(n));
    check({31'h0, irq_o}, 32'h1);
    wait_for(0, 1'b1, 70000, t2);
    check(32'(t2 - t0), 32'h0000_FFFF);
    reg_wr(`MTP_OFF_START, start_bits);
    idle(2);
    check({31'h0, pulse}, 32'h0);
    reg_wr(`MTP_OFF_INT_STAT, 32'h0000_00FF);
    // A channel, 8-bit with prescale; a reload written mid-run shows at the next cycle.
    n = 1 + ($random(seed) & 7);
    m = $random(seed) & 3;
    reg_wr(`MTP_OFF_A_MODE, 32'h0000_0004);
    reg_wr(`MTP_OFF_A_TIMER, 32'(n * 256 + m));
    reg_wr(`MTP_OFF_START, 32'h0000_0001);
    wait_for(0, 1'b1, 20, t0);
    wait_for(0, 1'b0, 80, t1);
    check(32'(t1 - t0), 32'(n * (m + 1)));
    reg_wr(`MTP_OFF_A_TIMER, 32'((n + 1) * 256 + m));
    wait_for(0, 1'b1, 1100, t2);
    check(32'(t2 - t0), 32'(255 * (m + 1)));
    wait_for(0, 1'b0, 80, t1);
    check(32'(t1 - t2), 32'((n + 1) * (m + 1)));
    reg_wr(`MTP_OFF_START, start_bits);
    // Pin trigger: armed channel waits, a second trigger mid-pulse must not stretch it.
    reg_wr(`MTP_OFF_A_MODE, 32'h0000_0008);
    reg_wr(`MTP_OFF_A_TIMER, 32'h0000_0006);
    reg_wr(`MTP_OFF_START, 32'h0000_0001);
    idle(8);
    check({31'h0, pulse}, 32'h0);
    trig <= 1'b1;
    wait_for(0, 1'b1, 8, t0);
    trig <= 1'b0;
    idle(1);
    trig <= 1'b1;
    wait_for(0, 1'b0, 20, t1);
    check(32'(t1 - t0), 32'h0000_0006);
    reg_wr(`MTP_OFF_START, start_bits);
    trig <= 1'b0;
    idle(2);
    give_verdict();
  end
endmodule
`default_nettype wire
